// ==== design/rps_consts.svh ====
// Constants for the remappable pin select block
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH

// Selector geometry
`define RPS_SEL_W 5
`define RPS_NUM_IN 14
`define RPS_IN_IDX_W 4
`define RPS_MAX_PINS 26
`define RPS_PIN_IDX_W 5

// Reset values of the selectors
`define RPS_IN_RESET 5'h1f
`define RPS_OUT_RESET 5'h00

// Input selector code that grounds the peripheral input
`define RPS_IN_GND 5'h1f

// Output selector codes
`define RPS_OUT_NULL 5'h00
`define RPS_OUT_UART_TX 5'h03
`define RPS_OUT_UART_RTS 5'h04
`define RPS_OUT_SPI_DO 5'h07
`define RPS_OUT_SPI_CLK 5'h08
`define RPS_OUT_SPI_SS 5'h09
`define RPS_OUT_CMP_ONE 5'h12
`define RPS_OUT_CMP_TWO 5'h13

// Oscillator control low byte: unlock keys and lock position
`define RPS_KEY_FIRST 8'h46
`define RPS_KEY_SECOND 8'h57
`define RPS_LOCK_BIT 6
`define RPS_LOCK_RESET 1'b0

`endif

// ==== design/rps_pkg.sv ====
// Types shared by the remappable pin select block
package rps_pkg;
  `include "rps_consts.svh"

  typedef logic [`RPS_SEL_W-1:0] rps_sel_t;

  // Peripheral inputs fed by the input selectors; bit 0 is ext_irq_one
  typedef struct packed {
    logic spi_select_in;
    logic spi_clock_in;
    logic spi_data_in;
    logic uart_clear_to_send_in;
    logic uart_receive_in;
    logic compare_fault_in;
    logic capture_in_eight;
    logic capture_in_seven;
    logic capture_in_two;
    logic capture_in_one;
    logic timer_three_ext_clock;
    logic timer_two_ext_clock;
    logic ext_irq_two;
    logic ext_irq_one;
  } rps_periph_in_t;

  // Peripheral outputs offered to the output selectors
  typedef struct packed {
    logic uart_transmit_out;
    logic uart_request_out;
    logic spi_data_out;
    logic spi_clock_out;
    logic spi_select_out;
    logic compare_out_one;
    logic compare_out_two;
  } rps_periph_out_t;

  // Unlock sequence tracker, Gray coded
  typedef enum logic [1:0] {
    RPS_WAIT_FIRST = 2'b00,
    RPS_WAIT_SECOND = 2'b01,
    RPS_ARMED = 2'b11
  } rps_unlock_t;
endpackage : rps_pkg

// ==== design/rps_shadow.sv ====
// Shadow copy of a selector bank with continuous comparison
`timescale 1ns/10ps
`include "rps_consts.svh"
module rps_shadow #(
  parameter int N = 14,
  parameter int IDX_W = 4,
  parameter logic [`RPS_SEL_W-1:0] FIELD_RESET = `RPS_IN_RESET
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Accepted writes, same as those taken by the primary bank
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire rps_pkg::rps_sel_t wr_data,
  // Primary bank being watched
  input wire rps_pkg::rps_sel_t primary [N],
  // Difference seen between shadow and primary
  output logic mismatch
);
  import rps_pkg::*;

  rps_sel_t shadow [N];
  logic differ;

  // Shadow follows only legitimate writes
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < N; i++) begin
        shadow[i] <= FIELD_RESET;
      end
    end else if (wr_en) begin
      shadow[wr_idx] <= wr_data;
    end
  end

  // Any field differing is an upset in one of the copies
  always_comb begin
    differ = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (shadow[i] != primary[i]) begin
        differ = 1'b1;
      end
    end
  end

  // Registered compare result
  always_ff @(posedge clk) begin
    if (reset) begin
      mismatch <= 1'b0;
    end else begin
      mismatch <= differ;
    end
  end
endmodule : rps_shadow

// ==== design/rps_top.sv ====
// Remappable peripheral pin select with lock and shadow monitoring
`timescale 1ns/10ps
`include "rps_consts.svh"

module rps_top #(
  parameter int NUM_PINS = `RPS_MAX_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration option, high means one write session only
  input wire logic one_way_lock_option,
  // Oscillator control register low byte write
  input wire logic osc_ctrl_wr,
  input wire logic [7:0] osc_ctrl_wdata,
  // Input selector writes
  input wire logic in_sel_wr,
  input wire logic [`RPS_IN_IDX_W-1:0] in_sel_idx,
  input wire rps_pkg::rps_sel_t in_sel_wdata,
  // Output selector writes
  input wire logic out_sel_wr,
  input wire logic [`RPS_PIN_IDX_W-1:0] out_sel_idx,
  input wire rps_pkg::rps_sel_t out_sel_wdata,
  // Selector readback addresses
  input wire logic [`RPS_IN_IDX_W-1:0] in_rd_idx,
  input wire logic [`RPS_PIN_IDX_W-1:0] out_rd_idx,
  // Remappable pin levels and peripheral outputs
  input wire logic [NUM_PINS-1:0] remappable_pin_in,
  input wire rps_pkg::rps_periph_out_t periph_out,
  // Routed peripheral inputs
  output rps_pkg::rps_periph_in_t periph_in,
  // Remappable pin drive; take high overrides the port function
  output logic [NUM_PINS-1:0] remappable_pin_out,
  output logic [NUM_PINS-1:0] remappable_pin_take,
  // Status and readback
  output logic map_write_lock,
  output logic [7:0] oscillator_control_reg,
  output rps_pkg::rps_sel_t in_rd_data,
  output rps_pkg::rps_sel_t out_rd_data,
  output logic config_mismatch_reset
);
  import rps_pkg::*;

  rps_sel_t input_route_regs [`RPS_NUM_IN];
  rps_sel_t output_route_regs [NUM_PINS];
  rps_unlock_t unlock_state;
  rps_unlock_t next_unlock_state;
  logic lock_set_once;
  logic next_lock;
  logic lock_change_ok;
  logic in_wr_ok;
  logic out_wr_ok;
  logic in_mismatch;
  logic out_mismatch;
  logic [`RPS_NUM_IN-1:0] routed;

  // Route one remappable pin to a peripheral input, or ground
  function automatic logic route_pin(input logic [NUM_PINS-1:0] pins,
                                     input rps_sel_t code);
    logic level;
    level = 1'b0;
    if (code != `RPS_IN_GND && int'(code) < NUM_PINS) begin
      level = pins[code];
    end
    return level;
  endfunction : route_pin

  // Pick the peripheral output named by an output selector code
  function automatic logic pick_out(input rps_periph_out_t po,
                                    input rps_sel_t code);
    logic level;
    level = 1'b0;
    case (code)
      `RPS_OUT_UART_TX: level = po.uart_transmit_out;
      `RPS_OUT_UART_RTS: level = po.uart_request_out;
      `RPS_OUT_SPI_DO: level = po.spi_data_out;
      `RPS_OUT_SPI_CLK: level = po.spi_clock_out;
      `RPS_OUT_SPI_SS: level = po.spi_select_out;
      `RPS_OUT_CMP_ONE: level = po.compare_out_one;
      `RPS_OUT_CMP_TWO: level = po.compare_out_two;
      default: level = 1'b0;
    endcase
    return level;
  endfunction : pick_out

  // Writes land only while unlocked; out of range indexes are dropped
  assign in_wr_ok = in_sel_wr && !map_write_lock &&
                    (int'(in_sel_idx) < `RPS_NUM_IN);
  assign out_wr_ok = out_sel_wr && !map_write_lock &&
                     (int'(out_sel_idx) < NUM_PINS);

  // Unlock sequence: first key, second key, then one lock write
  always_comb begin
    next_unlock_state = unlock_state;
    if (osc_ctrl_wr) begin
      unique case (unlock_state)
        RPS_WAIT_FIRST: begin
          if (osc_ctrl_wdata == `RPS_KEY_FIRST) begin
            next_unlock_state = RPS_WAIT_SECOND;
          end
        end
        RPS_WAIT_SECOND: begin
          if (osc_ctrl_wdata == `RPS_KEY_SECOND) begin
            next_unlock_state = RPS_ARMED;
          end else if (osc_ctrl_wdata == `RPS_KEY_FIRST) begin
            next_unlock_state = RPS_WAIT_SECOND;
          end else begin
            next_unlock_state = RPS_WAIT_FIRST;
          end
        end
        RPS_ARMED: begin
          // The single write that follows consumes the arming
          next_unlock_state = RPS_WAIT_FIRST;
        end
        default: next_unlock_state = RPS_WAIT_FIRST;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      unlock_state <= RPS_WAIT_FIRST;
    end else begin
      unlock_state <= next_unlock_state;
    end
  end

  // Lock may move only on the armed write, and one-way forbids clearing
  assign lock_change_ok = osc_ctrl_wr && (unlock_state == RPS_ARMED);
  assign next_lock = osc_ctrl_wdata[`RPS_LOCK_BIT];

  always_ff @(posedge clk) begin
    if (reset) begin
      map_write_lock <= `RPS_LOCK_RESET;
    end else if (lock_change_ok) begin
      if (next_lock) begin
        map_write_lock <= 1'b1;
      end else if (!(one_way_lock_option && lock_set_once)) begin
        map_write_lock <= 1'b0;
      end
    end
    // Otherwise the lock simply holds
  end

  // Remembers that the lock was set once this session
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_set_once <= 1'b0;
    end else if (lock_change_ok && next_lock) begin
      lock_set_once <= 1'b1;
    end
  end

  // Readable image of the register low byte; only the lock bit is stored
  always_ff @(posedge clk) begin
    if (reset) begin
      oscillator_control_reg <= 8'h00;
    end else begin
      oscillator_control_reg <= 8'h00;
      oscillator_control_reg[`RPS_LOCK_BIT] <= map_write_lock;
    end
  end

  // Input selector bank; reset grounds every peripheral input
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `RPS_NUM_IN; i++) begin
        input_route_regs[i] <= `RPS_IN_RESET;
      end
    end else if (in_wr_ok) begin
      input_route_regs[in_sel_idx] <= in_sel_wdata;
    end
  end

  // Output selector bank; reset leaves all pins to the port
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        output_route_regs[i] <= `RPS_OUT_RESET;
      end
    end else if (out_wr_ok) begin
      output_route_regs[out_sel_idx] <= out_sel_wdata;
    end
  end

  // Input muxes, one per peripheral input
  always_comb begin
    for (int i = 0; i < `RPS_NUM_IN; i++) begin
      routed[i] = route_pin(remappable_pin_in, input_route_regs[i]);
    end
  end

  // Registered so peripherals see a clean, glitch free level
  always_ff @(posedge clk) begin
    if (reset) begin
      periph_in <= '0;
    end else begin
      periph_in <= rps_periph_in_t'(routed);
    end
  end

  // Output muxes, one per remappable pin
  always_ff @(posedge clk) begin
    if (reset) begin
      remappable_pin_out <= '0;
      remappable_pin_take <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        remappable_pin_out[i] <= pick_out(periph_out,
                                          output_route_regs[i]);
        remappable_pin_take[i] <=
          (output_route_regs[i] != `RPS_OUT_NULL);
      end
    end
  end

  // Readback of the selectors; unfitted indexes read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      in_rd_data <= '0;
      out_rd_data <= '0;
    end else begin
      in_rd_data <= (int'(in_rd_idx) < `RPS_NUM_IN) ?
                    input_route_regs[in_rd_idx] : '0;
      out_rd_data <= (int'(out_rd_idx) < NUM_PINS) ?
                     output_route_regs[out_rd_idx] : '0;
    end
  end

  // Shadow banks see the same accepted writes as the primaries
  rps_shadow #(
    .N(`RPS_NUM_IN),
    .IDX_W(`RPS_IN_IDX_W),
    .FIELD_RESET(`RPS_IN_RESET)
  ) u_in_shadow (
    .clk(clk),
    .reset(reset),
    .wr_en(in_wr_ok),
    .wr_idx(in_sel_idx),
    .wr_data(in_sel_wdata),
    .primary(input_route_regs),
    .mismatch(in_mismatch)
  );

  rps_shadow #(
    .N(NUM_PINS),
    .IDX_W(`RPS_PIN_IDX_W),
    .FIELD_RESET(`RPS_OUT_RESET)
  ) u_out_shadow (
    .clk(clk),
    .reset(reset),
    .wr_en(out_wr_ok),
    .wr_idx(out_sel_idx),
    .wr_data(out_sel_wdata),
    .primary(output_route_regs),
    .mismatch(out_mismatch)
  );

  // Request for a device reset; a level until reset clears it
  always_ff @(posedge clk) begin
    if (reset) begin
      config_mismatch_reset <= 1'b0;
    end else if (in_mismatch || out_mismatch) begin
      config_mismatch_reset <= 1'b1;
    end
  end
endmodule : rps_top

// ==== tb/rps_top_sva.sv ====
// Checker for the remappable pin select block, bound to its top
`timescale 1ns/10ps
module rps_top_sva #(
  parameter int NUM_PINS = 26
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Lock controls
  input wire logic one_way_lock_option,
  input wire logic osc_ctrl_wr,
  input wire logic [7:0] osc_ctrl_wdata,
  // Readback addresses and far side levels
  input wire logic [3:0] in_rd_idx,
  input wire logic [4:0] out_rd_idx,
  input wire logic [NUM_PINS-1:0] remappable_pin_in,
  input wire rps_pkg::rps_periph_out_t periph_out,
  // Outputs under watch
  input wire rps_pkg::rps_periph_in_t periph_in,
  input wire logic [NUM_PINS-1:0] remappable_pin_out,
  input wire logic [NUM_PINS-1:0] remappable_pin_take,
  input wire logic map_write_lock,
  input wire logic [7:0] oscillator_control_reg,
  input wire rps_pkg::rps_sel_t in_rd_data,
  input wire rps_pkg::rps_sel_t out_rd_data,
  input wire logic config_mismatch_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [NUM_PINS-1:0] pin_q;
  // Pin levels one edge back, to line up with registered routing
  always_ff @(posedge clk) begin
    pin_q <= remappable_pin_in;
  end
  sequence lock_held;
    map_write_lock [*2];
  endsequence
  sequence set_write;
    $past(osc_ctrl_wr) && $past(osc_ctrl_wdata[6]);
  endsequence
  // Readback and pin drive are both one edge behind the selector
  property out_route(logic [4:0] c, logic src);
    $past(out_rd_idx) < NUM_PINS && out_rd_data == c |->
      remappable_pin_out[$past(out_rd_idx)] == $past(src);
  endproperty
  lock_hold_a: assert property (
    !osc_ctrl_wr |=> $stable(map_write_lock))
    else $error("lock moved without a write");
  lock_set_a: assert property ($rose(map_write_lock) |-> set_write)
    else $error("lock set without a write");
  lock_clear_a: assert property ($fell(map_write_lock) |->
    $past(osc_ctrl_wr) && !one_way_lock_option) else $error("bad clear");
  one_way_keep_a: assert property (
    one_way_lock_option && map_write_lock |=> map_write_lock)
    else $error("one-way lock cleared");
  osc_mirror_a: assert property (!$past(reset) |->
    oscillator_control_reg == {1'b0, $past(map_write_lock), 6'h00})
    else $error("lock bit not in osc reg");
  locked_stable_a: assert property (lock_held ##0
    in_rd_idx == $past(in_rd_idx) |=> $stable(in_rd_data))
    else $error("selector changed while locked");
  take_null_a: assert property ($past(out_rd_idx) < NUM_PINS |->
    remappable_pin_take[$past(out_rd_idx)] == (out_rd_data != 5'h00))
    else $error("take flag wrong");
  tx_route_a: assert property (
    out_route(5'h03, periph_out.uart_transmit_out)) else $error("tx");
  rts_route_a: assert property (
    out_route(5'h04, periph_out.uart_request_out)) else $error("rts");
  sdo_route_a: assert property (
    out_route(5'h07, periph_out.spi_data_out)) else $error("sdo");
  sck_route_a: assert property (
    out_route(5'h08, periph_out.spi_clock_out)) else $error("sck");
  ss_route_a: assert property (
    out_route(5'h09, periph_out.spi_select_out)) else $error("ss");
  cmp_one_a: assert property (
    out_route(5'h12, periph_out.compare_out_one)) else $error("cmp1");
  cmp_two_a: assert property (
    out_route(5'h13, periph_out.compare_out_two)) else $error("cmp2");
  in_route_a: assert property (!$past(reset) && $past(in_rd_idx) < 14
    && in_rd_data < NUM_PINS |->
    periph_in[$past(in_rd_idx)] == pin_q[in_rd_data]) else $error("in route");
  in_ground_a: assert property ($past(in_rd_idx) < 14 &&
    in_rd_data == 5'h1f |-> periph_in[$past(in_rd_idx)] == 1'b0)
    else $error("grounded input high");
  no_mismatch_a: assert property (!config_mismatch_reset)
    else $error("mismatch reset raised");
endmodule : rps_top_sva

bind rps_top rps_top_sva #(.NUM_PINS(NUM_PINS)) i_sva (.clk, .reset,
  .one_way_lock_option, .osc_ctrl_wr, .osc_ctrl_wdata, .in_rd_idx,
  .out_rd_idx, .remappable_pin_in, .periph_out, .periph_in,
  .remappable_pin_out, .remappable_pin_take, .map_write_lock,
  .oscillator_control_reg, .in_rd_data, .out_rd_data, .config_mismatch_reset);

// ==== tb/rps_far_model.sv ====
// Far side model: remappable pin levels and peripheral outputs
`timescale 1ns/10ps
module rps_far_model #(
  parameter int NUM_PINS = 26
) (
  // Clock
  input wire logic clk,
  // Levels seen by the block
  output logic [NUM_PINS-1:0] pins,
  output rps_pkg::rps_periph_out_t outs
);
  logic [NUM_PINS-1:0] ring = '0;
  logic [7:0] cnt = 8'h00;
  // Walking pattern so every pin toggles at its own time; the outputs follow a binary count
  always @(negedge clk) begin
    ring <= {ring[NUM_PINS-2:0], ~ring[NUM_PINS-1]};
    cnt <= cnt + 8'h01;
  end
  assign pins = ring;
  assign outs = rps_pkg::rps_periph_out_t'(cnt[6:0]);
endmodule : rps_far_model

// ==== tb/test_remappable_pin_select.sv ====
// Testbench for the remappable pin select block
`timescale 1ns/10ps
module test_remappable_pin_select;
  import rps_pkg::*;
  localparam int NP = 26;
  // Clock, reset and option
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic one_way = 1'b1;
  // Stimulus
  logic osc_wr = 1'b0;
  logic [7:0] osc_d = 8'h00;
  logic in_wr = 1'b0;
  logic out_wr = 1'b0;
  logic [3:0] in_idx = 4'h0;
  logic [4:0] out_idx = 5'h00;
  rps_sel_t sel_d = 5'h00;
  logic [3:0] in_ra = 4'h0;
  logic [4:0] out_ra = 5'h00;
  // Far side and results
  logic [NP-1:0] pins, pin_o, pin_t;
  rps_periph_out_t p_out;
  rps_periph_in_t p_in;
  logic lock, mism;
  logic [7:0] osc_q;
  rps_sel_t in_rd, out_rd;
  int n_fail = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  rps_far_model #(.NUM_PINS(NP)) i_far (.clk(clk), .pins(pins), .outs(p_out));
  rps_top #(.NUM_PINS(NP)) i_dut (.clk(clk), .reset(reset),
    .one_way_lock_option(one_way), .osc_ctrl_wr(osc_wr),
    .osc_ctrl_wdata(osc_d), .in_sel_wr(in_wr), .in_sel_idx(in_idx),
    .in_sel_wdata(sel_d), .out_sel_wr(out_wr), .out_sel_idx(out_idx),
    .out_sel_wdata(sel_d), .in_rd_idx(in_ra), .out_rd_idx(out_ra),
    .remappable_pin_in(pins), .periph_out(p_out), .periph_in(p_in),
    .remappable_pin_out(pin_o), .remappable_pin_take(pin_t),
    .map_write_lock(lock), .oscillator_control_reg(osc_q),
    .in_rd_data(in_rd), .out_rd_data(out_rd), .config_mismatch_reset(mism));
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Peripheral output level that an output selector code names
  function automatic logic exp_pin(rps_sel_t c, rps_periph_out_t po);
    case (c)
      5'h03: return po.uart_transmit_out;
      5'h04: return po.uart_request_out;
      5'h07: return po.spi_data_out;
      5'h08: return po.spi_clock_out;
      5'h09: return po.spi_select_out;
      5'h12: return po.compare_out_one;
      5'h13: return po.compare_out_two;
      default: return 1'b0;
    endcase
  endfunction : exp_pin
  // One-cycle strobes; the gap cycle keeps back-to-back calls clean
  task automatic osc(logic [7:0] d);
    @(negedge clk);
    osc_wr = 1'b1;
    osc_d = d;
    @(negedge clk);
    osc_wr = 1'b0;
  endtask : osc
  task automatic wr(logic o, logic [4:0] i, rps_sel_t d);
    @(negedge clk);
    in_wr = !o;
    out_wr = o;
    in_idx = i[3:0];
    out_idx = i;
    sel_d = d;
    @(negedge clk);
    in_wr = 1'b0;
    out_wr = 1'b0;
  endtask : wr
  // Readback lands one edge after the address
  task automatic rd(logic o, logic [4:0] i, rps_sel_t exp);
    @(negedge clk);
    in_ra = i[3:0];
    out_ra = i;
    repeat (2) @(negedge clk);
    chk("selector", {3'h0, exp}, {3'h0, o ? out_rd : in_rd});
  endtask : rd
  task automatic do_reset(logic ow);
    @(negedge clk);
    reset = 1'b1;
    one_way = ow;
    repeat (8) @(negedge clk);
    reset = 1'b0;
  endtask : do_reset
  task automatic t_reset;
    for (int i = 0; i < 14; i++) rd(0, i[4:0], 5'h1f);
    for (int i = 0; i < NP; i++) rd(1, i[4:0], 5'h00);
    chk("take", 8'h00, {7'h0, |pin_t});
    chk("osc reg", 8'h00, osc_q);
  endtask : t_reset
  task automatic t_one_way;
    osc(8'h46);
    osc(8'h00);
    osc(8'h40);
    chk("lock", 8'h00, {7'h0, lock});
    osc(8'h46);
    osc(8'h57);
    osc(8'h40);
    chk("lock", 8'h01, {7'h0, lock});
    @(negedge clk);
    chk("osc reg", 8'h40, osc_q);
    wr(0, 5'd9, 5'h03);
    rd(0, 5'd9, 5'h1f);
    osc(8'h46);
    osc(8'h57);
    osc(8'h00);
    chk("lock", 8'h01, {7'h0, lock});
  endtask : t_one_way
  task automatic t_session;
    osc(8'h46);
    osc(8'h57);
    osc(8'h40);
    osc(8'h46);
    osc(8'h57);
    osc(8'h00);
    chk("lock", 8'h00, {7'h0, lock});
    for (int i = 0; i < 14; i++) wr(0, i[4:0], 5'(i + 12));
    for (int i = 0; i < 14; i++) rd(0, i[4:0], 5'(i + 12));
    wr(0, 5'd0, 5'd26);
    repeat (3) begin
      @(negedge clk);
      chk("beyond pins", 8'h00, {7'h0, p_in[0]});
    end
  endtask : t_session
  task automatic t_outputs;
    rps_sel_t c [8] = '{5'h00, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12,
      5'h13};
    for (int i = 0; i < 8; i++) wr(1, i[4:0], c[i]);
    @(negedge clk);
    for (int i = 0; i < 8; i++) chk("take", {7'h0, c[i] != 5'h00}, {7'h0,
      pin_t[i]});
    // Far side levels still hold what the last rising edge sampled
    for (int i = 0; i < 8; i++) chk("pin drive",
      {7'h0, exp_pin(c[i], p_out)}, {7'h0, pin_o[i]});
    for (int i = 0; i < 8; i++) rd(1, i[4:0], c[i]);
    osc(8'h46);
    osc(8'h57);
    osc(8'h40);
    wr(1, 5'd0, 5'h03);
    rd(1, 5'd0, 5'h00);
    chk("mismatch", 8'h00, {7'h0, mism});
  endtask : t_outputs
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_one_way();
    do_reset(1'b0);
    t_session();
    t_outputs();
    results();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule : test_remappable_pin_select
